// ==== verilog/evt_map.svh ====
// register offsets, field layouts, reset values and source defaults of the event controller
// Notes on behaviour
// R1: several service routines may be active at once, lower ones stay suspended.
// R2: higher priority pending event is dispatched first and preempts lower service.
// R3: five event types: emulation, reset, nonmaskable, exception, interrupt.
// R4: emulation event puts the processor into emulation mode, JTAG controlled.
// R5: nonmaskable event comes from watchdog expiry or the nonmaskable pin.
// R6: exceptions are synchronous and taken before the faulting instruction completes.
// R7: interrupts arrive asynchronously from timers, peripherals, pins, software instruction.
// R8: each event has its own return address; state saved on supervisor stack.
// R9: peripheral requests enter the router, which feeds the core general levels.
// R10: core stage offers nine general levels, numbered 7 through 15.
// R11: software should keep levels 14 and 15 for software handlers.
// R12: fixed priorities, 0 highest, 0..15 as tabled, each with a vector entry.
// R13: router mapping defaults at reset; eight assignment registers change it.
// R14: wakeup, error, reserved and supplemental sources default to level 7.
// R15: first DMA controller channels 0 to 11 default to level 8.
// R16: second DMA controller channels 0 to 11 default to level 9.
// R17: memory DMA streams default to level 8 (first) and 9 (second).
// R18: timers 0..11 default to level 10; six flag interrupts to level 11.
// R19: internal memory DMA streams and watchdog default to level 12.
// R20: latch bit sets on input rising edge after two cycles, clears on pending.
// R21: set mask bit unmasks a level; cleared bit blocks service, latch stays.
// R22: pending bit stays set while its event is active or nested.
// R23: router gives per-source mask and status bits.
// R24: each general level input is OR of unmasked sources assigned to it.
// R25: dispatch highest latched unmasked level above every pending level, set pending.
// R26: assignment field is a binary code offset from level 7.
`ifndef EVT_MAP_SVH
`define EVT_MAP_SVH
`define EVT_NSRC 64
`define EVT_NLVL 16
`define EVT_GEN_BASE 7
// byte offsets on the register bus
`define EVT_OFF_LATCH 12'h000
`define EVT_OFF_MASK 12'h004
`define EVT_OFF_PEND 12'h008
`define EVT_OFF_RETURN 12'h00C
`define EVT_OFF_SWRAISE 12'h010
`define EVT_OFF_ACTIVE 12'h014
`define EVT_OFF_SMASK0 12'h020
`define EVT_OFF_SMASK1 12'h024
`define EVT_OFF_SSTAT0 12'h028
`define EVT_OFF_SSTAT1 12'h02C
`define EVT_OFF_ASSIGN0 12'h040
`define EVT_OFF_VEC0 12'h080
`define EVT_MASK_RST 16'h001F
`define EVT_SMASK_RST 32'h00000000
// default assignment codes, eight sources of four bits per register
`define EVT_ASSIGN_RST0 32'h00000000
`define EVT_ASSIGN_RST1 32'h11111000
`define EVT_ASSIGN_RST2 32'h21111111
`define EVT_ASSIGN_RST3 32'h22222222
`define EVT_ASSIGN_RST4 32'h33333222
`define EVT_ASSIGN_RST5 32'h43333333
`define EVT_ASSIGN_RST6 32'h21144444
`define EVT_ASSIGN_RST7 32'h00005552
`endif

// ==== verilog/evt_pkg.sv ====
// types shared by the event controller
package evt_pkg;
    typedef logic [15:0] lvl_vec_t;
    typedef struct packed {
        logic emulation;
        logic reset_req;
        logic nmi_pin;
        logic watchdog;
        logic exception;
        logic hw_error;
        logic core_timer;
    } core_evt_t;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_ENTER = 3'b010,
        ST_EMU = 3'b100
    } core_state_t;
endpackage : evt_pkg

// ==== verilog/edge_sync.sv ====
// three-stage synchroniser with rising edge detect for one input
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic level,
    output logic rise
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // level moves only when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            lvl_r <= s3_r;
        end
    end
    assign level = lvl_r;
    assign rise = (s2_r == s3_r) && s3_r && !lvl_r;
endmodule : edge_sync
`default_nettype wire

// ==== verilog/event_controller.sv ====
// two-stage event controller: source router plus core event stage with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "evt_map.svh"
module event_controller (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [63:0] periph_irq,
    input wire evt_pkg::core_evt_t core_evt,
    input wire logic event_return,
    output logic [15:0] event_pending_bits,
    output logic take_event,
    output logic [3:0] take_level,
    output logic [31:0] take_vector,
    output logic [31:0] take_return_addr,
    input wire logic [31:0] current_pc,
    output logic emulation_mode,
    output logic save_state
);
    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [15:0] event_latch_bits;
    logic [15:0] event_mask_bits;
    logic [15:0] pend_r;
    logic [63:0] source_mask_bits;
    logic [63:0] source_status_bits;
    logic [31:0] source_assign_regs [0:7];
    logic [31:0] vector_table [0:15];
    logic [31:0] ret_addr_r [0:15];
    logic [3:0] active_r;
    logic [3:0] take_level_r;
    logic take_r;
    logic emu_r;
    logic [31:0] take_vec_r;
    logic [31:0] take_ret_r;
    evt_pkg::core_state_t state_r;
    evt_pkg::core_state_t state_nxt;
    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    logic wr_en;
    logic rd_en;
    logic hit_assign;
    logic hit_vec;
    logic known;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign hit_assign = (paddr[11:5] == 7'(`EVT_OFF_ASSIGN0 >> 5)) && (paddr[1:0] == 2'h0);
    assign hit_vec = (paddr[11:6] == 6'(`EVT_OFF_VEC0 >> 6)) && (paddr[1:0] == 2'h0);
    assign pready = 1'b1;
    always_comb begin
        known = hit_assign || hit_vec;
        unique case (paddr)
            `EVT_OFF_LATCH, `EVT_OFF_MASK, `EVT_OFF_PEND, `EVT_OFF_RETURN,
            `EVT_OFF_SWRAISE, `EVT_OFF_ACTIVE, `EVT_OFF_SMASK0, `EVT_OFF_SMASK1,
            `EVT_OFF_SSTAT0, `EVT_OFF_SSTAT1: known = 1'b1;
            default: ;
        endcase
    end
    assign pslverr = psel && penable && !known;
    ////////////////////////////////////////////////////////////////////////////
    // router stage: synchronise sources, status, mask, assign to levels
    logic [63:0] src_lvl;
    genvar gi;
    generate
        for (gi = 0; gi < `EVT_NSRC; gi++) begin : g_src
            edge_sync u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .din(periph_irq[gi]),
                .level(src_lvl[gi]),
                .rise()
            );
        end
    endgenerate
    // R23 per-source status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_status_bits <= 64'h0;
        end else begin
            source_status_bits <= src_lvl;
        end
    end
    // R9 R10 R24 R26 or of unmasked sources per level
    logic [15:0] gen_in;
    always_comb begin
        logic [3:0] code;
        logic [4:0] lv;
        gen_in = 16'h0;
        code = 4'h0;
        lv = 5'h0;
        for (int s = 0; s < `EVT_NSRC; s++) begin
            code = source_assign_regs[s / 8][(s % 8) * 4 +: 4];
            lv = 5'(code) + 5'(`EVT_GEN_BASE);
            if (lv < 5'd16 && source_status_bits[s] && source_mask_bits[s]) begin
                gen_in[lv[3:0]] = 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // core stage inputs
    logic [15:0] raw_in;
    logic [15:0] raw_d_r;
    logic [15:0] rise_r;
    logic [15:0] sw_raise;
    // R3 R5 R7 event sources by class
    always_comb begin
        raw_in = gen_in;
        raw_in[0] = core_evt.emulation;
        raw_in[1] = core_evt.reset_req;
        raw_in[2] = core_evt.nmi_pin || core_evt.watchdog;
        raw_in[3] = core_evt.exception;
        raw_in[4] = 1'b0;
        raw_in[5] = core_evt.hw_error;
        raw_in[6] = core_evt.core_timer;
    end
    // R20 two-cycle edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_d_r <= 16'h0;
            rise_r <= 16'h0;
        end else begin
            raw_d_r <= raw_in;
            rise_r <= raw_in & ~raw_d_r;
        end
    end
    assign sw_raise = (wr_en && paddr == `EVT_OFF_SWRAISE) ? pwdata[15:0] : 16'h0;
    ////////////////////////////////////////////////////////////////////////////
    // selection
    logic [15:0] cand;
    logic found;
    logic [3:0] sel;
    logic [15:0] lat_clr;
    // R2 R12 R21 R25 highest unmasked latched level above pending
    always_comb begin
        cand = event_latch_bits & event_mask_bits;
        found = 1'b0;
        sel = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (cand[i]) begin
                found = 1'b1;
                sel = 4'(i);
            end
        end
        for (int i = 0; i < 16; i++) begin
            if (pend_r[i] && 4'(i) <= sel) begin
                found = 1'b0;
            end
        end
        if (state_r != evt_pkg::ST_RUN) begin
            found = 1'b0;
        end
    end
    assign lat_clr = found ? (16'h1 << sel) : 16'h0;
    // R20 latch set on edge, cleared on pending; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_latch_bits <= 16'h0;
        end else begin
            event_latch_bits <= (event_latch_bits & ~lat_clr
                & ~((wr_en && paddr == `EVT_OFF_LATCH) ? (pwdata[15:0] & ~event_mask_bits) : 16'h0))
                | rise_r | sw_raise;
        end
    end
    // R21 mask register; unmaskable levels forced on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_mask_bits <= `EVT_MASK_RST;
        end else if (wr_en && paddr == `EVT_OFF_MASK) begin
            event_mask_bits <= pwdata[15:0] | `EVT_MASK_RST;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // dispatch state machine
    // R1 R2 nesting through pending bits
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            evt_pkg::ST_RUN: if (found) state_nxt = evt_pkg::ST_ENTER;
            evt_pkg::ST_ENTER: state_nxt = (take_level_r == 4'h0) ? evt_pkg::ST_EMU : evt_pkg::ST_RUN;
            evt_pkg::ST_EMU: if (event_return) state_nxt = evt_pkg::ST_RUN;
            default: state_nxt = evt_pkg::ST_RUN;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= evt_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end
    // R4 emulation mode flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emu_r <= 1'b0;
        end else begin
            emu_r <= (state_nxt == evt_pkg::ST_EMU);
        end
    end
    // lowest set pending bit is the active event
    logic [3:0] top_active;
    logic any_pend;
    always_comb begin
        top_active = 4'h0;
        any_pend = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (pend_r[i]) begin
                top_active = 4'(i);
                any_pend = 1'b1;
            end
        end
    end
    // R22 pending set on take, cleared on return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= 16'h0;
        end else begin
            pend_r <= (pend_r & ~((event_return && any_pend) ? (16'h1 << top_active) : 16'h0)) | lat_clr;
        end
    end
    // R6 R8 take strobe, vector and per-event return address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take_r <= 1'b0;
            take_level_r <= 4'h0;
            take_vec_r <= 32'h0;
            take_ret_r <= 32'h0;
        end else begin
            take_r <= found;
            if (found) begin
                take_level_r <= sel;
                take_vec_r <= vector_table[sel];
            end
            if (event_return && any_pend) begin
                take_ret_r <= ret_addr_r[top_active];
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                ret_addr_r[i] <= 32'h0;
            end
        end else if (found) begin
            ret_addr_r[sel] <= current_pc;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_r <= 4'hF;
        end else begin
            active_r <= any_pend ? top_active : 4'hF;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // software-written router and vector state
    // R13 R14 R15 R16 R17 R18 R19 default assignment at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_assign_regs[0] <= `EVT_ASSIGN_RST0;
            source_assign_regs[1] <= `EVT_ASSIGN_RST1;
            source_assign_regs[2] <= `EVT_ASSIGN_RST2;
            source_assign_regs[3] <= `EVT_ASSIGN_RST3;
            source_assign_regs[4] <= `EVT_ASSIGN_RST4;
            source_assign_regs[5] <= `EVT_ASSIGN_RST5;
            source_assign_regs[6] <= `EVT_ASSIGN_RST6;
            source_assign_regs[7] <= `EVT_ASSIGN_RST7;
        end else if (wr_en && hit_assign) begin
            source_assign_regs[paddr[4:2]] <= pwdata;
        end
    end
    // R23 per-source mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_mask_bits <= {`EVT_SMASK_RST, `EVT_SMASK_RST};
        end else if (wr_en && paddr == `EVT_OFF_SMASK0) begin
            source_mask_bits[31:0] <= pwdata;
        end else if (wr_en && paddr == `EVT_OFF_SMASK1) begin
            source_mask_bits[63:32] <= pwdata;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                vector_table[i] <= 32'h0;
            end
        end else if (wr_en && hit_vec) begin
            vector_table[paddr[5:2]] <= pwdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // read mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (hit_assign) begin
                prdata <= source_assign_regs[paddr[4:2]];
            end else if (hit_vec) begin
                prdata <= vector_table[paddr[5:2]];
            end else begin
                unique case (paddr)
                    `EVT_OFF_LATCH: prdata <= {16'h0, event_latch_bits};
                    `EVT_OFF_MASK: prdata <= {16'h0, event_mask_bits};
                    `EVT_OFF_PEND: prdata <= {16'h0, pend_r};
                    `EVT_OFF_RETURN: prdata <= take_ret_r;
                    `EVT_OFF_ACTIVE: prdata <= {28'h0, active_r};
                    `EVT_OFF_SMASK0: prdata <= source_mask_bits[31:0];
                    `EVT_OFF_SMASK1: prdata <= source_mask_bits[63:32];
                    `EVT_OFF_SSTAT0: prdata <= source_status_bits[31:0];
                    `EVT_OFF_SSTAT1: prdata <= source_status_bits[63:32];
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end
    assign event_pending_bits = pend_r;
    assign take_event = take_r;
    assign take_level = take_level_r;
    assign take_vector = take_vec_r;
    assign take_return_addr = take_ret_r;
    assign emulation_mode = emu_r;
    assign save_state = take_r;
    wire unused_ok = rd_en;
endmodule : event_controller
`default_nettype wire

// ==== tb/evt_checker_sva.sv ====
// port assertions for the event controller
`timescale 1ns/1ps
`default_nettype none
module evt_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic event_return,
    input wire logic [15:0] event_pending_bits,
    input wire logic take_event,
    input wire logic [3:0] take_level,
    input wire logic emulation_mode,
    input wire logic save_state
);
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] low_r;
    logic mapped;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_r <= 16'h0000;
        end else begin
            low_r <= event_pending_bits & (~event_pending_bits + 16'h0001);
        end
    end
    assign mapped = (paddr[1:0] == 2'b00) && ((paddr[11:2] <= 10'h005)
        || (paddr[11:2] >= 10'h008 && paddr[11:2] <= 10'h00B)
        || (paddr[11:2] >= 10'h010 && paddr[11:2] <= 10'h017) || (paddr[11:2] >= 10'h020 && paddr[11:2] <= 10'h02F));
    sequence s_take;
        take_event;
    endsequence
    sequence s_ret;
        event_return && (event_pending_bits != 16'h0000) && !take_event;
    endsequence
    ////////////////////////////////////////////////////////////////
    // state saved on take
    a_save_on_take: assert property (save_state == take_event) else $error("save differs from take");
    a_take_pulse: assert property (s_take |=> !take_event) else $error("take longer than a cycle");
    a_take_pend: assert property (s_take |-> event_pending_bits[take_level]) else $error("taken not pending");
    a_take_above: assert property (s_take |-> (($past(event_pending_bits) & ((16'h0002 << take_level) - 16'h0001))
        == 16'h0000)) else $error("take not above pending");
    a_pend_hold: assert property (!take_event && !$past(event_return) |-> $stable(event_pending_bits))
        else $error("pending changed alone");
    a_ret_clear: assert property (s_ret |=> (event_pending_bits & low_r) == 16'h0000)
        else $error("return left level pending");
    a_emu_enter: assert property (s_take and take_level == 4'h0 |-> ##[0:1] emulation_mode)
        else $error("no emulation mode");
    a_emu_hold: assert property (emulation_mode && !event_return |=> emulation_mode) else $error("emulation dropped");
    a_err_map: assert property (pslverr == (psel && penable && !mapped)) else $error("slave error wrong");
    a_ready_one: assert property (pready) else $error("ready low");
endmodule : evt_checker
bind event_controller evt_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .event_return(event_return),
    .event_pending_bits(event_pending_bits), .take_event(take_event), .take_level(take_level),
    .emulation_mode(emulation_mode), .save_state(save_state));
`default_nettype wire

// ==== tb/far_side.sv ====
// peripheral sources and core pipeline model
`timescale 1ns/1ps
`default_nettype none
module far_side (
    input wire logic pclk,
    output logic [63:0] periph_irq,
    output evt_pkg::core_evt_t core_evt,
    output logic event_return
);
    logic [6:0] ce_r = 7'h00;
    assign core_evt = evt_pkg::core_evt_t'(ce_r);
    initial begin
        periph_irq = 64'h0;
        event_return = 1'b0;
    end
    task automatic src(input int i, input logic v);
        @(posedge pclk);
        periph_irq[i] <= v;
    endtask : src
    task automatic core(input int i, input logic v);
        @(posedge pclk);
        ce_r[i] <= v;
    endtask : core
    task automatic ret(input int d);
        repeat (d) @(posedge pclk);
        event_return <= 1'b1;
        @(posedge pclk);
        event_return <= 1'b0;
    endtask : ret
endmodule : far_side
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the event controller
`timescale 1ns/1ps
`default_nettype none
`include "evt_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch at %0t: got %0h want %0h", $time, g, e); end end
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] current_pc = 32'h0;
    logic [31:0] prdata, take_vector, take_return_addr, rd, e;
    logic pready, pslverr, take_event, emulation_mode, save_state, event_return, err;
    logic [15:0] event_pending_bits;
    logic [3:0] take_level;
    logic [63:0] periph_irq;
    evt_pkg::core_evt_t core_evt;
    int bad_count = 0;
    int checks = 0;
    int n;
    logic [35:0] note_q[$];
    logic [35:0] nt;
    logic [31:0] vec [16];
    logic [3:0] clv [7] = '{4'h6, 4'h5, 4'h3, 4'h2, 4'h2, 4'h1, 4'h0};
    always #2.5 pclk = ~pclk;
    event_controller uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_irq(periph_irq), .core_evt(core_evt), .event_return(event_return),
        .event_pending_bits(event_pending_bits), .take_event(take_event), .take_level(take_level),
        .take_vector(take_vector), .take_return_addr(take_return_addr), .current_pc(current_pc),
        .emulation_mode(emulation_mode), .save_state(save_state));
    far_side u_far (.pclk(pclk), .periph_irq(periph_irq), .core_evt(core_evt), .event_return(event_return));
    ////////////////////////////////////////////////////////////////
    // taken level and vector
    always @(posedge pclk) begin
        if (take_event === 1'b1) begin
            nt = (note_q.size() != 0) ? note_q.pop_front() : 36'hFFFFFFFFF;
            `CHK({take_level, take_vector}, nt)
        end
    end
    function automatic logic [3:0] dflt(input int i);
        if (i < 11 || i > 59) return 4'h0;
        if (i < 23 || i == 53 || i == 54) return 4'h1;
        if (i < 35 || i == 55 || i == 56) return 4'h2;
        if (i < 47) return 4'h3;
        if (i < 53) return 4'h4;
        return 4'h5;
    endfunction : dflt
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(rd, x)
    endtask : rdchk
    task automatic expect_take(input logic [3:0] l);
        note_q.push_back({l, vec[l]});
    endtask : expect_take
    task automatic wait_take();
        n = 0;
        while (take_event !== 1'b1 && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
        @(posedge pclk);
    endtask : wait_take
    task automatic one_src(input int i, input logic [3:0] l);
        logic [31:0] pc;
        pc = $urandom;
        current_pc <= pc;
        expect_take(l);
        u_far.src(i, 1'b1);
        wait_take();
        `CHK(n, 8);
        `CHK(event_pending_bits[l], 1'b1);
        rdchk(i < 32 ? `EVT_OFF_SSTAT0 : `EVT_OFF_SSTAT1, 32'h1 << (i % 32));
        u_far.src(i, 1'b0);
        u_far.ret($urandom_range(1, 4));
        repeat (2) @(posedge pclk);
        `CHK(take_return_addr, pc);
        `CHK(event_pending_bits, 16'h0000);
    endtask : one_src
    task automatic give_verdict();
        `CHK(note_q.size(), 0)
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        bad_count++;
        $display("mismatch at %0t: run too long", $time);
        give_verdict();
    end
    initial begin
        void'($urandom(15444));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int l = 0; l < 16; l++) begin
            vec[l] = $urandom;
            apb(1'b1, `EVT_OFF_VEC0 + 12'(4 * l), vec[l]);
        end
        rdchk(`EVT_OFF_MASK, 32'h0000001F);
        rdchk(`EVT_OFF_SMASK0, 32'h0);
        for (int r = 0; r < 8; r++) begin
            for (int j = 0; j < 8; j++) e[4 * j +: 4] = dflt(8 * r + j);
            rdchk(`EVT_OFF_ASSIGN0 + 12'(4 * r), e);
        end
        apb(1'b0, 12'h030, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b1, `EVT_OFF_MASK, 32'h0000FFFF);
        apb(1'b1, `EVT_OFF_SMASK0, 32'hFFFFFFFF);
        apb(1'b1, `EVT_OFF_SMASK1, 32'hFFFFFFFF);
        for (int i = 0; i < 64; i++) one_src(i, 4'(7 + dflt(i)));
        expect_take(4'hA);
        u_far.src(35, 1'b1);
        wait_take();
        expect_take(4'h8);
        u_far.src(11, 1'b1);
        wait_take();
        `CHK(event_pending_bits, 16'h0500);
        u_far.src(57, 1'b1);
        repeat (12) @(posedge pclk);
        `CHK(event_pending_bits, 16'h0500);
        u_far.ret(1);
        repeat (12) @(posedge pclk);
        `CHK(event_pending_bits, 16'h0400);
        expect_take(4'hC);
        u_far.ret(1);
        wait_take();
        `CHK(event_pending_bits, 16'h1000);
        u_far.ret(1);
        u_far.src(35, 1'b0);
        u_far.src(11, 1'b0);
        u_far.src(57, 1'b0);
        apb(1'b1, `EVT_OFF_MASK, 32'h0000FBFF);
        u_far.src(36, 1'b1);
        repeat (12) @(posedge pclk);
        rdchk(`EVT_OFF_LATCH, 32'h00000400);
        expect_take(4'hA);
        apb(1'b1, `EVT_OFF_MASK, 32'h0000FFFF);
        wait_take();
        rdchk(`EVT_OFF_LATCH, 32'h0);
        u_far.src(36, 1'b0);
        u_far.ret(2);
        apb(1'b1, `EVT_OFF_SMASK1, 32'hFFFFFFF7);
        u_far.src(35, 1'b1);
        repeat (12) @(posedge pclk);
        `CHK(event_pending_bits, 16'h0000);
        u_far.src(35, 1'b0);
        repeat (8) @(posedge pclk);
        apb(1'b1, `EVT_OFF_SMASK1, 32'hFFFFFFFF);
        apb(1'b1, `EVT_OFF_ASSIGN0 + 12'h010, 32'h33337222);
        one_src(35, 4'hE);
        apb(1'b1, `EVT_OFF_ASSIGN0 + 12'h010, 32'h33333222);
        for (int l = 14; l < 16; l++) begin
            expect_take(4'(l));
            apb(1'b1, `EVT_OFF_SWRAISE, 32'h1 << l);
            wait_take();
            u_far.ret(1);
        end
        for (int b = 0; b < 7; b++) begin
            expect_take(clv[b]);
            u_far.core(b, 1'b1);
            wait_take();
            @(negedge pclk);
            `CHK(emulation_mode, 1'(b == 6));
            u_far.core(b, 1'b0);
            u_far.ret(1);
            repeat (2) @(posedge pclk);
            `CHK(emulation_mode, 1'b0);
        end
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK({take_event, emulation_mode, event_pending_bits, take_return_addr}, 50'h0);
        presetn <= 1'b1;
        rdchk(`EVT_OFF_MASK, 32'h0000001F);
        rdchk(`EVT_OFF_ACTIVE, 32'h0000000F);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
